// ---- design/rshp_pkg.sv ----
package rshp_pkg;

   // Reference clock and serial clock periods, all in ns
   localparam int CLK_PERIOD_NS     = 8;
   localparam int I2C_SCL_PERIOD_NS = 2500;
   localparam int SPI_SCL_PERIOD_NS = 160;

   // One quarter of a serial clock period in REF_CLK cycles, rounded up
   localparam int I2C_QUARTER_CYC =
      (I2C_SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);
   localparam int SPI_QUARTER_CYC =
      (SPI_SCL_PERIOD_NS + 4 * CLK_PERIOD_NS - 1) / (4 * CLK_PERIOD_NS);

   // Two-wire slave address and direction bit values
   localparam logic [6:0] SLAVE_ADDR = 7'h53;
   localparam logic       DIR_WRITE  = 1'h0;
   localparam logic       DIR_READ   = 1'h1;

   // Command byte layout of the four-line port
   localparam int CMD_DIR_BIT  = 7;
   localparam int CMD_ADDR_MSB = 6;

   // Bit index of the acknowledge slot, last data bit index
   localparam logic [3:0] ACK_BIT  = 4'h8;
   localparam logic [3:0] LAST_BIT = 4'h7;

   // Reset values
   localparam logic [7:0] BYTE_RST = 8'h00;

   // Controller states, one-hot
   typedef enum logic [4:0] {
      ST_IDLE  = 5'h01,
      ST_START = 5'h02,
      ST_LOAD  = 5'h04,
      ST_BYTE  = 5'h08,
      ST_STOP  = 5'h10
   } rshp_state_t;

   // Which byte of the message is on the wire
   typedef enum logic [1:0] {
      PH_DEV  = 2'h0,
      PH_REG  = 2'h1,
      PH_DEVR = 2'h2,
      PH_DATA = 2'h3
   } rshp_phase_t;

   // One transfer request from the user side
   typedef struct packed {
      logic       rw;
      logic [6:0] addr;
      logic [7:0] len;
   } rshp_cmd_t;

endpackage

// ---- design/rshp_fifo.sv ----
`timescale 1ns/1ns
module rshp_fifo #(
   parameter int W = 8,
   parameter int D = 8
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Filling side
   input  wire logic         in_valid,
   input  wire logic [W-1:0] in_data,
   output logic              in_ready,
   // Draining side
   output logic              out_valid,
   output logic [W-1:0]      out_data,
   input  wire logic         out_ready
);
   localparam int AW = $clog2(D);

   logic [W-1:0]  mem [D];
   logic [AW-1:0] wptr;
   logic [AW-1:0] rptr;
   logic [AW:0]   cnt;

   // Head word moves into the output register whenever it is free
   wire           push     = in_valid && in_ready;
   wire           pull     = (cnt != '0) && (!out_valid || out_ready);
   wire [AW:0]    next_cnt = cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pull};
   // Output register is one of the D words, else the buffer holds D+1
   wire           next_ov  = pull || (out_valid && !out_ready);
   wire [AW+1:0]  next_fill = {1'b0, next_cnt} + {{(AW+1){1'b0}}, next_ov};

   // Storage has no reset; only pointers and flags are control state
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wptr] <= in_data;
      end
      if (pull) begin
         out_data <= mem[rptr];
      end
   end

   // Pointers, fill count and registered full flag
   always_ff @(posedge clk) begin
      if (rst) begin
         wptr      <= '0;
         rptr      <= '0;
         cnt       <= '0;
         in_ready  <= 1'b0;
         out_valid <= 1'b0;
      end else begin
         wptr      <= push ? wptr + 1'b1 : wptr;
         rptr      <= pull ? rptr + 1'b1 : rptr;
         cnt       <= next_cnt;
         in_ready  <= next_fill < (AW+2)'(D);
         out_valid <= next_ov;
      end
   end
endmodule

// ---- design/rshp_host.sv ----
`timescale 1ns/1ns
module rshp_host
   import rshp_pkg::*;
#(
   parameter int FIFO_DEPTH = 8
) (
   // Clock and reset
   input  wire logic       REF_CLK,
   input  wire logic       RST,
   // Command request
   input  wire logic       MODE_I2C,
   input  wire logic       CMD_VALID,
   input  wire rshp_cmd_t  CMD,
   output logic            CMD_READY,
   // Write data stream
   input  wire logic       WR_VALID,
   input  wire logic [7:0] WR_DATA,
   output logic            WR_READY,
   // Read data
   output logic            RD_VALID,
   output logic [7:0]      RD_DATA,
   // Status
   output logic            BUSY,
   output logic            DONE,
   output logic            ERR,
   input  wire logic       MAIN_PWR_OK,
   // Device pins
   output logic            BUS_SELECT_PIN,
   output logic            SCL_O,
   output logic            SCL_OE_N,
   input  wire logic       SDA_I,
   output logic            SDA_O,
   output logic            SDA_OE_N,
   output logic            SERIAL_IN_LINE,
   input  wire logic       SERIAL_OUT_LINE
);
   rshp_state_t st;
   rshp_phase_t phase;
   rshp_cmd_t   cur;
   logic        i2c;
   logic [1:0]  q;
   logic [6:0]  qcnt;
   logic [3:0]  bitn;
   logic [7:0]  shreg;
   logic [7:0]  rx;
   logic [7:0]  cnt;
   logic        tx;
   logic        nack;
   logic        recov;
   logic        scl;
   logic        sda;
   logic        rd_pulse;
   logic        done_pulse;
   logic [2:0]  sync1;
   logic [2:0]  sync2;
   logic        fifo_valid;
   logic [7:0]  fifo_data;

   // Pins from the far side pass two flops before anyone looks at them
   always_ff @(posedge REF_CLK) begin
      sync1 <= {SDA_I, SERIAL_OUT_LINE, MAIN_PWR_OK};
      sync2 <= sync1;
   end

   // Decoding of synchronised inputs and sequencing conditions
   wire       sda_s    = sync2[2];
   wire       sdo_s    = sync2[1];
   wire       pwr_s    = sync2[0];
   wire       tick     = (qcnt == 7'h00);
   wire [6:0] quarter  = i2c ? 7'(I2C_QUARTER_CYC - 1)
                             : 7'(SPI_QUARTER_CYC - 1);
   wire       in_bit   = i2c ? sda_s : sdo_s;
   wire [3:0] last_idx = i2c ? ACK_BIT : LAST_BIT;
   wire       accept   = (st == ST_IDLE) && CMD_VALID && CMD_READY;
   wire       need_wr  = (phase == PH_DATA) && !cur.rw && (cnt != 8'h00);
   wire       pop      = (st == ST_LOAD) && need_wr && fifo_valid;
   wire       rd_data  = (phase == PH_DATA) && cur.rw;

   // Byte to shift next; on the two-wire port the slave address goes before the register address
   wire [7:0] spi_cmd  = {cur.rw, cur.addr};
   wire [7:0] dev_byte = {SLAVE_ADDR, (phase == PH_DEVR) ? DIR_READ
                                                         : DIR_WRITE};
   wire [7:0] load_byte =
      (phase == PH_DATA) ? (cur.rw ? (i2c ? 8'hff : BYTE_RST) : fifo_data)
    : (phase == PH_REG)  ? {1'b0, cur.addr}
    : i2c                ? dev_byte
    :                      spi_cmd;

   // Write data waits here; the engine stalls in LOAD while it is empty
   rshp_fifo #(.W(8), .D(FIFO_DEPTH)) u_fifo (
      .clk       (REF_CLK),
      .rst       (RST),
      .in_valid  (WR_VALID),
      .in_data   (WR_DATA),
      .in_ready  (WR_READY),
      .out_valid (fifo_valid),
      .out_data  (fifo_data),
      .out_ready (pop)
   );

   // Quarter-period timebase; held at phase 0 while idle or loading
   always_ff @(posedge REF_CLK) begin
      if (RST || st == ST_IDLE || st == ST_LOAD) begin
         qcnt <= 7'h00;
         q    <= 2'h0;
      end else begin
         qcnt <= tick ? quarter : qcnt - 7'h01;
         q    <= tick ? q + 2'h1 : q;
      end
   end

   // Bus sequencer
   always_ff @(posedge REF_CLK) begin
      rd_pulse   <= 1'b0;
      done_pulse <= 1'b0;
      if (RST) begin
         st    <= ST_IDLE;
         phase <= PH_DEV;
         cur   <= '0;
         i2c   <= 1'b0;
         bitn  <= 4'h0;
         shreg <= BYTE_RST;
         rx    <= BYTE_RST;
         cnt   <= BYTE_RST;
         tx    <= 1'b1;
         nack  <= 1'b0;
         recov <= 1'b1;
         scl   <= 1'b0;
         sda   <= 1'b1;
         ERR   <= 1'b0;
      end else if (!pwr_s && st != ST_IDLE) begin
         st    <= ST_IDLE;
         ERR   <= 1'b1;
         recov <= recov || i2c;
         scl   <= i2c;
         sda   <= 1'b1;
         // The caller still sees the cut transfer end, flagged by ERR
         done_pulse <= 1'b1;
      end else begin
         case (st)
            ST_IDLE: begin
               i2c <= MODE_I2C;
               scl <= MODE_I2C;               // Idle clock level per mode
               sda <= 1'b1;
               if (accept) begin
                  cur   <= CMD;
                  cnt   <= CMD.len;
                  phase <= PH_DEV;
                  ERR   <= 1'b0;
                  st    <= (recov && i2c) ? ST_STOP : ST_START;
               end
            end
            ST_START: if (tick) begin
               case (q)
                  2'h0: sda <= i2c;
                  2'h1: scl <= i2c;
                  2'h2: sda <= i2c ? 1'b0 : sda;
                  default: begin
                     scl <= 1'b0;
                     st  <= ST_LOAD;
                  end
               endcase
            end
            ST_LOAD: begin
               bitn <= 4'h0;
               nack <= 1'b0;
               if (phase == PH_DATA && cnt == 8'h00) begin
                  st <= ST_STOP;
               end else if (!need_wr || fifo_valid) begin
                  shreg <= load_byte;
                  tx    <= !rd_data;
                  st    <= ST_BYTE;
               end
            end
            ST_BYTE: if (tick) begin
               case (q)
                  2'h0: scl <= 1'b0;
                  2'h1: begin                 // Change data with clock low
                     if (bitn != ACK_BIT) begin
                        sda <= i2c ? (!tx || shreg[7]) : sda;
                     end else begin
                        sda <= tx || (cnt == 8'h01);
                     end
                  end
                  2'h2: begin
                     scl <= 1'b1;
                     if (bitn != ACK_BIT) begin
                        rx <= {rx[6:0], in_bit};
                     end else begin
                        nack <= tx && in_bit;
                     end
                  end
                  default: begin
                     if (bitn != last_idx) begin
                        bitn  <= bitn + 4'h1;
                        shreg <= {shreg[6:0], 1'b0};
                     end else if (nack) begin
                        ERR <= 1'b1;
                        st  <= ST_STOP;
                     end else begin
                        st <= ST_LOAD;
                        case (phase)
                           PH_DEV:  phase <= i2c ? PH_REG : PH_DATA;
                           PH_REG: begin
                              phase <= cur.rw ? PH_DEVR : PH_DATA;
                              st    <= cur.rw ? ST_START : ST_LOAD;
                              // Clock low first, so the slave lets go of
                              // its acknowledge before the restart
                              scl   <= !cur.rw;
                           end
                           PH_DEVR: phase <= PH_DATA;
                           default: begin
                              cnt      <= cnt - 8'h01;
                              rd_pulse <= cur.rw;
                           end
                        endcase
                     end
                  end
               endcase
            end
            ST_STOP: if (tick) begin
               case (q)
                  2'h0: scl <= 1'b0;
                  2'h1: sda <= i2c ? 1'b0 : sda;
                  2'h2: scl <= i2c;
                  default: begin
                     sda        <= 1'b1;
                     // A four-line frame leaves a pending recovery alone
                     recov      <= recov && !i2c;
                     done_pulse <= !(recov && i2c);
                     st         <= (recov && i2c) ? ST_START : ST_IDLE;
                  end
               endcase
            end
            default: st <= ST_IDLE;
         endcase
      end
   end

   // Every output leaves from a flop; open-drain lines only pull low
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         BUS_SELECT_PIN <= 1'b0;
         SCL_O          <= 1'b0;
         SCL_OE_N       <= 1'b0;
         SDA_O          <= 1'b1;
         SDA_OE_N       <= 1'b0;
         SERIAL_IN_LINE <= 1'b0;
         CMD_READY      <= 1'b0;
         RD_VALID       <= 1'b0;
         RD_DATA        <= BYTE_RST;
         BUSY           <= 1'b0;
         DONE           <= 1'b0;
      end else begin
         BUS_SELECT_PIN <= i2c;
         SCL_O          <= i2c ? 1'b0 : scl;
         SCL_OE_N       <= i2c ? scl : 1'b0;
         SDA_O          <= i2c ? 1'b0 : sda;
         SDA_OE_N       <= i2c ? sda : 1'b0;
         SERIAL_IN_LINE <= shreg[7];
         CMD_READY      <= (st == ST_IDLE) && !accept && pwr_s;
         RD_VALID       <= rd_pulse;
         RD_DATA        <= rx;
         BUSY           <= (st != ST_IDLE);
         DONE           <= done_pulse;
      end
   end

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);

   // Chip enable stays high for at least two cycles after a frame
   sequence s_ce_high;
      sda [*2];
   endsequence

   property p_spi_clk_idle;
      !i2c && sda |-> !scl;
   endproperty
   a_spi_clk_idle: assert property (p_spi_clk_idle)
      else $error("Serial clock toggles with chip enable high");

   property p_sdi_stable_rise;
      !i2c && $rose(scl) |-> $stable(shreg[7]);
   endproperty
   a_sdi_stable_rise: assert property (p_sdi_stable_rise)
      else $error("Serial input line moves on rising clock");

   property p_ce_gap;
      !i2c && $rose(sda) |-> s_ce_high;
   endproperty
   a_ce_gap: assert property (p_ce_gap)
      else $error("Chip enable high time too short");

   property p_sda_stable_high;
      i2c && st == ST_BYTE && scl && $past(scl) |-> $stable(sda);
   endproperty
   a_sda_stable_high: assert property (p_sda_stable_high)
      else $error("Data line moved while clock high inside a byte");

   property p_start_shape;
      i2c && $fell(sda) && scl |-> st == ST_START ##1 scl [*2];
   endproperty
   a_start_shape: assert property (p_start_shape)
      else $error("Data fall with clock high outside START");

   property p_stop_shape;
      i2c && $rose(sda) && scl && $past(scl) |-> $past(st) == ST_STOP;
   endproperty
   a_stop_shape: assert property (p_stop_shape)
      else $error("Data rise with clock high outside STOP");

   property p_addr_byte;
      i2c && st == ST_BYTE && bitn == 4'h0 && phase == PH_DEV
         |-> shreg == {SLAVE_ADDR, DIR_WRITE};
   endproperty
   a_addr_byte: assert property (p_addr_byte)
      else $error("Wrong slave address byte");

   property p_master_ack;
      i2c && st == ST_BYTE && rd_data && bitn == ACK_BIT && q == 2'h2
         && tick |-> sda == (cnt == 8'h01);
   endproperty
   a_master_ack: assert property (p_master_ack)
      else $error("Master acknowledge level wrong for read byte");

   property p_read_restart;
      i2c && st == ST_BYTE && phase == PH_REG && cur.rw && q == 2'h3
         && tick && bitn == ACK_BIT && !nack
         |=> st == ST_START && phase == PH_DEVR;
   endproperty
   a_read_restart: assert property (p_read_restart)
      else $error("Read did not follow register byte with restart");
endmodule

// ---- test/rshp_dev_model.sv ----
`timescale 1ns/1ns
module rshp_dev_model
   import rshp_pkg::*;
(
   // Mode and supply
   input  wire logic bus_sel,
   input  wire logic pwr,
   // Two-wire lines; pull is the open-drain low drive
   input  wire logic scl,
   input  wire logic sda,
   output logic      pull,
   // Four-line data lines
   input  wire logic serial_in_line,
   output logic      serial_out_line
);
   // Own copy of the slave address, kept apart from the host's constant
   localparam logic [6:0] DEV_ADDR = 7'h53;
   localparam logic [6:0] LAST_REG = 7'h36;
   logic [7:0] mem [0:54];
   logic [7:0] sr, tx;
   logic [6:0] ptr;
   logic [3:0] cnt;
   logic [1:0] st;
   logic       first, rw, mack;
   int         i;

   // Mode decode; on backup supply neither port reacts, except that chip enable high still restarts four-line framing
   wire act_spi = !bus_sel && pwr && !sda;
   wire act_i2c = bus_sel && pwr;

   function automatic logic [6:0] nxt(input logic [6:0] p);
      return (p == LAST_REG) ? 7'h00 : p + 7'h01;
   endfunction

   // Register contents follow a simple pattern the bench can predict
   initial begin
      for (i = 0; i < 55; i++) mem[i] = 8'h80 | 8'(i);
      pull = 1'h0; serial_out_line = 1'h0; st = 2'h0; cnt = 4'h0; first = 1'h1;
      rw = 1'h0; mack = 1'h0; ptr = 7'h00; sr = 8'h00; tx = 8'h00;
   end

   // Chip enable high restarts framing and inverts the output line
   always @(posedge sda) if (!bus_sel) begin
      cnt = 4'h0; first = 1'h1; serial_out_line = ~serial_out_line;
   end
   always @(posedge scl) if (act_spi) begin
      sr = {sr[6:0], serial_in_line};
      cnt = cnt + 4'h1;
      if (cnt == 4'h8) begin
         cnt = 4'h0;
         if (first) begin
            rw = sr[7]; ptr = sr[6:0]; first = 1'h0;
         end else if (!rw) begin
            mem[ptr] = sr; ptr = nxt(ptr);
         end
         if (rw) begin
            tx = mem[ptr]; ptr = nxt(ptr);
         end
      end
   end
   always @(negedge scl) if (act_spi) begin
      serial_out_line = tx[7]; tx = {tx[6:0], 1'h0};
   end

   // Data edges while the clock is high are control conditions
   always @(negedge sda) if (act_i2c && scl) begin
      st = 2'h1; cnt = 4'h0; pull = 1'h0;
   end
   always @(posedge sda) if (act_i2c && scl) begin
      st = 2'h0; pull = 1'h0;
   end
   // Switchover drops any two-wire message in progress
   always @(negedge pwr) begin
      st = 2'h0; pull = 1'h0;
   end
   always @(posedge scl) if (act_i2c && st != 2'h0) begin
      if (cnt < 4'h8) sr = {sr[6:0], sda};
      else mack = !sda;
      cnt = (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
   end
   // Drive changes only with the clock low, so no false conditions
   always @(negedge scl) if (act_i2c && st != 2'h0) begin
      pull = 1'h0;
      if (cnt == 4'h8 && st == 2'h1) begin
         if (sr[7:1] == DEV_ADDR) begin
            pull = 1'h1; st = sr[0] ? 2'h3 : 2'h2; first = 1'h1;
         end else st = 2'h0;
      end else if (cnt == 4'h8 && st == 2'h2) begin
         pull = 1'h1;
         if (first) ptr = sr[6:0];
         else begin
            mem[ptr] = sr; ptr = nxt(ptr);
         end
         first = 1'h0;
      end else if (cnt == 4'h0 && st == 2'h3 && !mack) st = 2'h0;
      else if (st == 2'h3 && cnt != 4'h8) begin
         if (cnt == 4'h0) begin
            tx = mem[ptr]; ptr = nxt(ptr);
         end
         pull = !tx[7]; tx = {tx[6:0], 1'h0};
      end
   end
endmodule

// ---- test/tb.sv ----
`timescale 1ns/1ns
module tb;
   import rshp_pkg::*;
   localparam int LIM = 40000;
   logic       REF_CLK, RST, MODE_I2C, CMD_VALID, WR_VALID, MAIN_PWR_OK;
   logic       CMD_READY, WR_READY, RD_VALID, BUSY, DONE, ERR;
   logic       BUS_SELECT_PIN, SCL_O, SCL_OE_N, SDA_O, SDA_OE_N;
   logic       SERIAL_IN_LINE, SERIAL_OUT_LINE, pull, dev_pwr;
   logic [7:0] WR_DATA, RD_DATA;
   rshp_cmd_t  CMD;
   int         errors, comparisons, got;
   logic [7:0] rq [$];
   // Both lines have pull-ups; any driver low wins
   wire        scl = SCL_OE_N ? 1'h1 : SCL_O;
   wire        sda = (SDA_OE_N ? 1'h1 : SDA_O) & !pull;

   rshp_host u_rshp_host (.REF_CLK(REF_CLK), .RST(RST), .MODE_I2C(MODE_I2C),
      .CMD_VALID(CMD_VALID), .CMD(CMD), .CMD_READY(CMD_READY),
      .WR_VALID(WR_VALID), .WR_DATA(WR_DATA), .WR_READY(WR_READY),
      .RD_VALID(RD_VALID), .RD_DATA(RD_DATA), .BUSY(BUSY), .DONE(DONE),
      .ERR(ERR), .MAIN_PWR_OK(MAIN_PWR_OK), .BUS_SELECT_PIN(BUS_SELECT_PIN),
      .SCL_O(SCL_O), .SCL_OE_N(SCL_OE_N), .SDA_I(sda), .SDA_O(SDA_O),
      .SDA_OE_N(SDA_OE_N), .SERIAL_IN_LINE(SERIAL_IN_LINE),
      .SERIAL_OUT_LINE(SERIAL_OUT_LINE));
   rshp_dev_model u_rshp_dev_model (.bus_sel(BUS_SELECT_PIN), .pwr(dev_pwr),
      .scl(scl), .sda(sda), .pull(pull), .serial_in_line(SERIAL_IN_LINE),
      .serial_out_line(SERIAL_OUT_LINE));

   initial begin
      REF_CLK = 1'h0;
      forever #4 REF_CLK = ~REF_CLK;
   end

   task automatic report_and_stop();
      $display("Compared %0d, mismatches %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   task automatic check(input string nm, input logic [7:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic hang();
      errors++;
      $display("Error wait expected handshake seen none");
      report_and_stop();
   endtask

   function automatic rshp_cmd_t mk(input logic r, input logic [6:0] a,
                                    input logic [7:0] n);
      return '{rw: r, addr: a, len: n};
   endfunction

   // Offer bytes base, base+1 ... until want taken or want+4 cycles have passed
   task automatic fill(input logic [7:0] base, input int want,
                       output int taken);
      int n;
      taken = 0;
      WR_VALID <= 1'h1;
      WR_DATA <= base;
      for (n = 0; n < want + 4 && taken < want; n++) begin
         @(posedge REF_CLK);
         if (WR_READY === 1'h1) begin
            taken++;
            WR_DATA <= base + 8'(taken);
         end
      end
      WR_VALID <= 1'h0;
   endtask

   // One command, collecting read bytes; cut drops both supplies mid-way
   task automatic run(input rshp_cmd_t c, input int cut);
      int n;
      rq.delete();
      CMD <= c;
      CMD_VALID <= 1'h1;
      n = 0;
      @(posedge REF_CLK);
      while (CMD_READY !== 1'h1) begin
         n++;
         if (n > LIM) hang();
         @(posedge REF_CLK);
      end
      CMD_VALID <= 1'h0;
      n = 0;
      do begin
         @(posedge REF_CLK);
         n++;
         if (n == cut) begin
            MAIN_PWR_OK <= 1'h0;
            dev_pwr <= 1'h0;
         end
         if (RD_VALID === 1'h1) rq.push_back(RD_DATA);
         if (n > LIM) hang();
      end while (DONE !== 1'h1);
   endtask

   // Full buffer, then one long four-line write drains it
   task automatic spi_write_full();
      fill(8'h40, 9, got);
      check("fifo_taken", 8'(got), 8'h08);
      run(mk(1'h0, 7'h10, 8'h08), 0);
      for (int k = 0; k < 8; k++)
         check("spi_mem", u_rshp_dev_model.mem[16 + k], 8'h40 + 8'(k));
      check("bus_sel", {7'h00, BUS_SELECT_PIN}, 8'h00);
      check("ce_idle", {7'h00, sda}, 8'h01);
   endtask

   // Four-line read across the last register
   task automatic spi_read_wrap();
      run(mk(1'h1, 7'h35, 8'h03), 0);
      check("spi_cnt", 8'(rq.size()), 8'h03);
      check("spi_rd0", rq[0], 8'hb5);
      check("spi_rd1", rq[1], 8'hb6);
      check("spi_rd2", rq[2], 8'h80);
   endtask

   // Two-wire write at the last register, second byte wraps
   task automatic i2c_write();
      MODE_I2C <= 1'h1;
      fill(8'h11, 2, got);
      run(mk(1'h0, 7'h36, 8'h02), 0);
      check("i2c_mem36", u_rshp_dev_model.mem[54], 8'h11);
      check("i2c_mem00", u_rshp_dev_model.mem[0], 8'h12);
      check("i2c_err", {7'h00, ERR}, 8'h00);
      check("bus_sel", {7'h00, BUS_SELECT_PIN}, 8'h01);
      check("busy", {7'h00, BUSY}, 8'h00);
      check("idle", {6'h00, scl, sda}, 8'h03);
   endtask

   task automatic i2c_read();
      run(mk(1'h1, 7'h36, 8'h02), 0);
      check("i2c_cnt", 8'(rq.size()), 8'h02);
      check("i2c_rd0", rq[0], 8'h11);
      check("i2c_rd1", rq[1], 8'h12);
      check("idle", {6'h00, scl, sda}, 8'h03);
   endtask

   // Device on backup supply: no acknowledge, host flags it
   task automatic backup_ignore();
      dev_pwr <= 1'h0;
      run(mk(1'h1, 7'h00, 8'h01), 0);
      check("bk_err", {7'h00, ERR}, 8'h01);
      check("bk_cnt", 8'(rq.size()), 8'h00);
      dev_pwr <= 1'h1;
   endtask

   // Switchover mid-message, then recovery with STOP and START
   task automatic power_abort();
      run(mk(1'h1, 7'h10, 8'h04), 600);
      check("ab_err", {7'h00, ERR}, 8'h01);
      check("ab_lines", {6'h00, scl, sda}, 8'h03);
      check("ab_ready", {7'h00, CMD_READY}, 8'h00);
      MAIN_PWR_OK <= 1'h1;
      dev_pwr <= 1'h1;
      repeat (10) @(posedge REF_CLK);
      run(mk(1'h1, 7'h10, 8'h01), 0);
      check("rc_rd", rq[0], 8'h40);
      check("rc_err", {7'h00, ERR}, 8'h00);
   endtask

   initial begin
      errors = 0;
      comparisons = 0;
      RST = 1'h1;
      MODE_I2C = 1'h0;
      CMD_VALID = 1'h0;
      CMD = 16'h0000;
      WR_VALID = 1'h0;
      WR_DATA = 8'h00;
      MAIN_PWR_OK = 1'h1;
      dev_pwr = 1'h1;
      repeat (20) @(posedge REF_CLK);
      RST <= 1'h0;
      spi_write_full();
      spi_read_wrap();
      i2c_write();
      i2c_read();
      backup_ignore();
      power_abort();
      report_and_stop();
   end
endmodule
